// file: rtl/i2c_switch_port.sv
// Two-wire slave port that loads the channel-select value of a bus switch.
`timescale 1ns/1ps
module i2c_switch_port #(
    parameter logic [i2c_switch_pkg::ADDR_W-1:0] OWN_ADDR = 7'h70
) (
    // System clock domain
    input  wire logic                              mclk,
    input  wire logic                              rst,
    // Link clock domain (serial clock pin)
    input  wire logic                              sclClk,
    // Serial data pin
    input  wire logic                              sdaIn,
    output logic                                   sdaOut,
    output logic                                   sdaOe,
    // Active channel selection
    output logic [i2c_switch_pkg::CHAN_W-1:0]      chanSel
);

    ////////////////////////////////////////////////////////////////////////
    // Start and stop detection on the system clock, sampled line levels.

    typedef enum logic [2:0] {IDLE, ADDR, ADDR_ACK, WR_DATA, WR_ACK, RD_DATA,
                              RD_ACK, IGNORE} port_e;

    i2c_switch_pkg::line_s line, lineQ;
    i2c_switch_pkg::line_s pinLevel;
    logic startEv, stopEv;

    assign pinLevel = '{scl: sclClk, sda: sdaIn};

    line_sync u_sync (
        .clk     (mclk),
        .rst     (rst),
        .pinIn   (pinLevel),
        .lineOut (line)
    );

    always_ff @(posedge mclk) begin
        if (rst) begin
            lineQ <= '1;
        end else begin
            lineQ <= line;
        end
    end

    assign startEv = line.scl && lineQ.scl && lineQ.sda && !line.sda;
    assign stopEv  = line.scl && lineQ.scl && !lineQ.sda && line.sda;

    logic sclRise, sclFall;
    assign sclRise = line.scl && !lineQ.scl;
    assign sclFall = !line.scl && lineQ.scl;

    ////////////////////////////////////////////////////////////////////////
    // Byte engine. The link clock is observed through the synchroniser so
    // that START and STOP, which happen while it stands high, are seen.

    port_e state_q;
    logic [i2c_switch_pkg::BIT_CNT_W-1:0] bitCnt_q;
    logic [i2c_switch_pkg::BYTE_W-1:0]    shift_q;
    logic [i2c_switch_pkg::CHAN_W-1:0]    pend_q;
    logic                                 pendValid_q;
    logic                                 ackSeen_q;

    function automatic logic addrHit(input logic [7:0] b);
        return b[7:1] == OWN_ADDR;
    endfunction : addrHit

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q  <= IDLE;
            bitCnt_q <= '0;
            shift_q  <= '0;
        end else if (startEv) begin
            state_q  <= ADDR;
            bitCnt_q <= '0;
        end else if (stopEv) begin
            state_q  <= IDLE;
        end else begin
            unique case (state_q)
                IDLE, IGNORE: begin
                    bitCnt_q <= '0;
                end
                ADDR, WR_DATA: begin
                    if (sclRise) begin
                        shift_q  <= {shift_q[6:0], line.sda};
                        bitCnt_q <= bitCnt_q + 4'h1;
                    end
                    if (sclFall && bitCnt_q == i2c_switch_pkg::ACK_SLOT) begin
                        bitCnt_q <= '0;
                        if (state_q == WR_DATA) begin
                            state_q <= WR_ACK;
                        end else if (addrHit(shift_q)) begin
                            state_q <= ADDR_ACK;
                        end else begin
                            state_q <= IGNORE;
                        end
                    end
                end
                ADDR_ACK: begin
                    if (sclFall) begin
                        state_q <= (shift_q[0] == i2c_switch_pkg::DIR_WRITE) ?
                                   WR_DATA : RD_DATA;
                        shift_q <= {i2c_switch_pkg::CHAN_RST, chanSel};
                    end
                end
                WR_ACK: begin
                    if (sclFall) begin
                        state_q <= WR_DATA;
                    end
                end
                RD_DATA: begin
                    if (sclFall) begin
                        if (bitCnt_q == i2c_switch_pkg::LAST_BIT) begin
                            bitCnt_q <= '0;
                            state_q  <= RD_ACK;
                        end else begin
                            bitCnt_q <= bitCnt_q + 4'h1;
                            shift_q  <= {shift_q[6:0], 1'b0};
                        end
                    end
                end
                RD_ACK: begin
                    if (sclFall) begin
                        state_q <= ackSeen_q ? RD_DATA : IGNORE;
                        shift_q <= {i2c_switch_pkg::CHAN_RST, chanSel};
                    end
                end
            endcase
        end
    end

    // Master acknowledge on a read is sampled on the ninth rising edge.
    always_ff @(posedge mclk) begin
        if (rst) begin
            ackSeen_q <= 1'b0;
        end else if (state_q == RD_ACK && sclRise) begin
            ackSeen_q <= !line.sda;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data pin drive. Changes happen two cycles after a detected falling clock, or one cycle after a start or stop.

    always_ff @(posedge mclk) begin
        if (rst) begin
            sdaOe <= 1'b0;
        end else begin
            unique case (state_q)
                ADDR_ACK, WR_ACK: sdaOe <= !stopEv && !startEv;
                RD_DATA:          sdaOe <= !shift_q[7] && !stopEv && !startEv;
                default:          sdaOe <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        sdaOut <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pending selection; later bytes overwrite earlier ones.

    always_ff @(posedge mclk) begin
        if (rst) begin
            pend_q      <= i2c_switch_pkg::CHAN_RST;
            pendValid_q <= 1'b0;
        end else if (startEv) begin
            pendValid_q <= 1'b0;
        end else if (state_q == WR_DATA && sclFall
                     && bitCnt_q == i2c_switch_pkg::ACK_SLOT) begin
            pend_q      <= shift_q[i2c_switch_pkg::CHAN_W-1:0];
            pendValid_q <= 1'b1;
        end else if (stopEv) begin
            pendValid_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            chanSel <= i2c_switch_pkg::CHAN_RST;
        end else if (stopEv && pendValid_q) begin
            chanSel <= pend_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    AST_IDLE_RELEASED: assert property (@(posedge mclk) disable iff (rst)
        (state_q == IDLE || state_q == IGNORE) |=> !sdaOe)
        else $error("Data line driven while not addressed.");

    AST_SEL_ONLY_STOP: assert property (@(posedge mclk) disable iff (rst)
        !stopEv |=> $stable(chanSel))
        else $error("Channel selection changed without a stop.");

    AST_ACK_DRIVE: assert property (@(posedge mclk) disable iff (rst)
        (state_q == ADDR_ACK && !startEv && !stopEv) |=> sdaOe)
        else $error("Address acknowledge not driven.");

    AST_SEL_LOAD: assert property (@(posedge mclk) disable iff (rst)
        (stopEv && pendValid_q) |=> chanSel == $past(pend_q))
        else $error("Channel selection not loaded at stop.");

    AST_START_ADDR: assert property (@(posedge mclk) disable iff (rst)
        startEv |=> state_q == ADDR && bitCnt_q == 4'h0)
        else $error("Start not followed by address phase.");

    AST_WR_ACK: assert property (@(posedge mclk) disable iff (rst)
        (state_q == WR_ACK && !startEv && !stopEv) |=> sdaOe)
        else $error("Write byte not acknowledged.");

    AST_NACK_END: assert property (@(posedge mclk) disable iff (rst)
        (state_q == RD_ACK && sclFall && !ackSeen_q && !startEv && !stopEv)
        |=> state_q == IGNORE)
        else $error("Read continued after not-acknowledge.");

    AST_STABLE_HIGH: assert property (@(posedge mclk) disable iff (rst)
        (line.scl && lineQ.scl && state_q == RD_DATA && !startEv && !stopEv)
        |=> $stable(sdaOe))
        else $error("Data changed while clock high.");

    AST_DIR: assert property (@(posedge mclk) disable iff (rst)
        (state_q == ADDR_ACK && sclFall && !startEv && !stopEv && shift_q[0])
        |=> state_q == RD_DATA)
        else $error("Read direction not honoured.");

endmodule : i2c_switch_port

// file: rtl/i2c_switch_pkg.sv
// Shared constants and carrier types for the two-wire switch control port.
package i2c_switch_pkg;

    localparam int ADDR_W     = 7;
    localparam int BYTE_W     = 8;
    localparam int CHAN_W     = 4;
    localparam int BIT_CNT_W  = 4;
    localparam logic [BIT_CNT_W-1:0] ACK_SLOT = 4'h8;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'h7;
    localparam logic [CHAN_W-1:0]    CHAN_RST = 4'h0;
    localparam logic                 DIR_WRITE = 1'b0;
    localparam int SYNC_STAGES = 3;

    // Serial line levels as seen by the slave after filtering.
    typedef struct packed {
        logic scl;
        logic sda;
    } line_s;

    // Toggle-based event carried from the link domain to the system domain.
    typedef struct packed {
        logic            tog;
        logic [CHAN_W-1:0] chan;
    } commit_s;

endpackage : i2c_switch_pkg

// file: rtl/line_sync.sv
// Three-stage synchroniser for the serial lines with agreement filtering.
`timescale 1ns/1ps
module line_sync #(
    parameter int STAGES = i2c_switch_pkg::SYNC_STAGES
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Raw pins and filtered levels
    input  wire i2c_switch_pkg::line_s pinIn,
    output i2c_switch_pkg::line_s      lineOut
);

    i2c_switch_pkg::line_s stage_q [STAGES];

    // The first stage feeds only the second; a level is accepted once the
    // last two stages agree, so one metastable sample never leaks through.
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < STAGES; i++) begin
                stage_q[i] <= '1;
            end
            lineOut <= '1;
        end else begin
            stage_q[0] <= pinIn;
            for (int i = 1; i < STAGES; i++) begin
                stage_q[i] <= stage_q[i-1];
            end
            if (stage_q[STAGES-1].scl == stage_q[STAGES-2].scl) begin
                lineOut.scl <= stage_q[STAGES-1].scl;
            end
            if (stage_q[STAGES-1].sda == stage_q[STAGES-2].sda) begin
                lineOut.sda <= stage_q[STAGES-1].sda;
            end
        end
    end

endmodule : line_sync

// file: verif/i2c_master_model.sv
// Behavioural two-wire bus master that drives the serial clock and pulls data low.
`timescale 1ns/1ps
module i2c_master_model (
    // Timing base and resolved data line
    input  wire logic linkClk,
    input  wire logic sdaLine,
    // Driven clock level and data pull-down
    output logic      sclClk,
    output logic      sdaOe
);
    // The clock rests high between frames and never runs free.
    initial begin
        sclClk = 1'b1;
        sdaOe  = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge linkClk);
    endtask : tick

    // Works from idle and as a repeated start after an acknowledge slot.
    task automatic start_cond();
        tick(2); sdaOe = 1'b0;
        tick(2); sclClk = 1'b1;
        tick(2); sdaOe = 1'b1;
        tick(2); sclClk = 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        tick(2); sdaOe = 1'b1;
        tick(2); sclClk = 1'b1;
        tick(2); sdaOe = 1'b0;
        tick(4);
    endtask : stop_cond

    // Data moves only in the low phase; the slave's answer is read mid-high.
    task automatic one_bit(input logic b, output logic s);
        tick(2); sdaOe = ~b;
        tick(2); sclClk = 1'b1;
        tick(2); s = sdaLine;
        tick(2); sclClk = 1'b0;
    endtask : one_bit

    task automatic send_bits(input logic [7:0] data, input int n);
        logic s;
        for (int i = 0; i < n; i++) begin
            one_bit(data[7-i], s);
        end
    endtask : send_bits

    task automatic write_byte(input logic [7:0] data, output logic ack);
        send_bits(data, 8);
        one_bit(1'b1, ack);
    endtask : write_byte

    task automatic read_byte(input logic nack, output logic [7:0] data);
        logic s;
        for (int i = 0; i < 8; i++) begin
            one_bit(1'b1, data[7-i]);
        end
        one_bit(nack, s);
    endtask : read_byte
endmodule : i2c_master_model

// file: verif/i2c_switch_port_test.sv
// Self-checking bench for the switch control port against a bus master model.
`timescale 1ns/1ps
module i2c_switch_port_test;
    localparam logic [6:0] ADDR = 7'h70;
    logic       mclk    = 1'b0;
    logic       rst     = 1'b1;
    logic       linkClk = 1'b0;
    logic       watch   = 1'b0;
    logic       sclClk;
    logic       masterOe;
    logic       sdaOut;
    logic       sdaOe;
    logic [3:0] chanSel;
    int         error_cnt = 0;
    int         n_tests   = 0;
    // Pull-up on the data line: released means high.
    wire        sdaLine = ~(masterOe | (sdaOe & ~sdaOut));

    always #12.5 mclk = ~mclk;
    // The link base starts off the system grid so edges never coincide.
    initial begin
        #7;
        forever #62.5 linkClk = ~linkClk;
    end

    i2c_switch_port #(.OWN_ADDR(ADDR)) dut (
        .mclk(mclk), .rst(rst), .sclClk(sclClk), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .chanSel(chanSel)
    );
    i2c_master_model master (
        .linkClk(linkClk), .sdaLine(sdaLine), .sclClk(sclClk), .sdaOe(masterOe)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask : check

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    task automatic wr(input logic [7:0] b, input logic expAck);
        logic a;
        master.write_byte(b, a);
        check("ack", {7'h0, expAck}, {7'h0, a});
    endtask : wr

    task automatic sel_is(input logic [3:0] exp);
        // The slave keeps its acknowledge for a few cycles past the clock fall.
        repeat (8) @(negedge mclk);
        check("chanSel", {4'h0, exp}, {4'h0, chanSel});
        check("sdaOe", 8'h00, {7'h0, sdaOe});
        check("sdaOut", 8'h00, {7'h0, sdaOut});
    endtask : sel_is

    // The slave must never move the data line while the clock is high.
    always @(sdaOe) begin
        if (watch && sclClk === 1'b1) begin
            $display("mismatch sdaOe expected steady seen %b", sdaOe);
            error_cnt++;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // No downstream targets share an address here, so any channel mix is legal.
    task automatic test_write_single();
        master.start_cond();
        wr({ADDR, 1'b0}, 1'b0);
        wr(8'hF5, 1'b0);
        sel_is(4'h0);
        master.stop_cond();
        sel_is(4'h5);
    endtask : test_write_single

    task automatic test_multi_byte();
        master.start_cond();
        wr({ADDR, 1'b0}, 1'b0);
        wr(8'h0A, 1'b0);
        wr(8'h03, 1'b0);
        sel_is(4'h5);
        master.stop_cond();
        sel_is(4'h3);
    endtask : test_multi_byte

    task automatic test_wrong_addr();
        master.start_cond();
        wr({ADDR ^ 7'h01, 1'b0}, 1'b1);
        wr(8'h0F, 1'b1);
        master.stop_cond();
        sel_is(4'h3);
    endtask : test_wrong_addr

    task automatic test_read();
        logic [7:0] d;
        master.start_cond();
        wr({ADDR, 1'b1}, 1'b0);
        master.read_byte(1'b0, d);
        check("read byte", 8'h03, d);
        master.read_byte(1'b1, d);
        check("second read byte", 8'h03, d);
        master.stop_cond();
        sel_is(4'h3);
    endtask : test_read

    task automatic test_partial();
        master.start_cond();
        wr({ADDR, 1'b0}, 1'b0);
        master.send_bits(8'hC0, 4);
        master.stop_cond();
        sel_is(4'h3);
        master.start_cond();
        wr({ADDR, 1'b0}, 1'b0);
        master.send_bits(8'hA0, 4);
        master.start_cond();
        wr({ADDR, 1'b0}, 1'b0);
        wr(8'h0C, 1'b0);
        master.stop_cond();
        sel_is(4'hC);
    endtask : test_partial

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge mclk);
        @(negedge mclk) rst = 1'b0;
        sel_is(4'h0);
        repeat (6) @(negedge mclk);
        watch = 1'b1;
        test_write_single();
        test_multi_byte();
        test_wrong_addr();
        test_read();
        test_partial();
        give_verdict();
    end

    // About 15 bytes of traffic, some 150 us in all, fit well inside this span.
    initial begin
        #1000000;
        error_cnt++;
        give_verdict();
    end
endmodule : i2c_switch_port_test
